// *** pkg/tmps_defs.svh ***
// Offsets, field positions and reset values of the transmit pin selector
`ifndef TMPS_DEFS_SVH
`define TMPS_DEFS_SVH
`define TMPS_NPORT          8
`define TMPS_OFF_CFG_LO     12'h000
`define TMPS_OFF_CFG_HI     12'h004
`define TMPS_OFF_CTRL       12'h008
`define TMPS_OFF_STAT       12'h00c
`define TMPS_CTRL_TRI_BIT   0
`define TMPS_CTRL_DRX_BIT   1
`define TMPS_CTRL_EDGE_BIT  2
`define TMPS_CFG_RST        32'h0000_0000
`define TMPS_CTRL_RST       3'h0
`endif

// *** pkg/tmps_pkg.sv ***
// Types for the transmit multifunction pin selector
package tmps_pkg;
   typedef enum logic [3:0] {
      TMPS_FN_TRI_HI  = 4'h8,
      TMPS_FN_GPI     = 4'h9,
      TMPS_FN_OUT_HI  = 4'ha,
      TMPS_FN_OUT_LO  = 4'hb,
      TMPS_FN_NEG_IN  = 4'hd,
      TMPS_FN_TRI_LO  = 4'he
   } tmps_fn_e;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
   } tmps_pins_s;
endpackage

// *** rtl/tmps_top.sv ***
// Transmit multifunction pin function select for eight line ports
// What this block does
// - Each pin A and B of every port takes its role from its own 4-bit code.
// - After reset every pin is an input until software picks a function.
// - The output enable of a pin follows the direction of its code.
// - Code 1001 makes the pin a general input shown in the status register.
// - Code 1010 drives the pin constantly high.
// - Code 1011 drives the pin as the fixed low-level output.
// - Code 1101 takes negative-rail data when dual-rail mode is enabled.
// - Code 1110 tristates the line on a low pin level, ORed with software.
// - Data is latched on the framer clock edge chosen by the edge bit.
// - An unconnected pin reads high because of its pull-up.
// - Code 1000 tristates the line on a high pin level, ORed with software.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "tmps_defs.svh"
module tmps_top
   import tmps_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [11:0]      paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic      [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o,
   input  wire tmps_pins_s       pin_i,
   output tmps_pins_s            pin_o,
   output tmps_pins_s            pin_oe_o,
   input  wire logic [7:0]       fclk_i,
   input  wire logic [7:0]       neg_data_i,
   output logic      [7:0]       neg_data_o,
   output logic      [7:0]       line_tristate_o
);
   logic [1:0]  rst_sync_q;
   logic        rst_b;
   logic [31:0] cfg_lo_q;
   logic [31:0] cfg_hi_q;
   logic [2:0]  ctrl_q;
   tmps_pins_s  pin_s1_q;
   tmps_pins_s  pin_s2_q;
   logic [7:0]  fclk_s1_q;
   logic [7:0]  fclk_s2_q;
   logic [7:0]  fclk_s3_q;
   logic [7:0]  negin_s1_q;
   logic [7:0]  negin_s2_q;
   logic [7:0]  neg_q;
   tmps_pins_s  gpi_q;
   logic [7:0]  tri_line_q;
   logic [31:0] prdata_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_q[1];

   function automatic logic [3:0] fn_of(input logic [31:0] lo,
                                        input logic [31:0] hi,
                                        input int idx);
      logic [63:0] all;
      all   = {hi, lo};
      fn_of = all[idx*4 +: 4];
   endfunction

   function automatic logic fn_is_out(input logic [3:0] f);
      fn_is_out = (f == TMPS_FN_OUT_HI) || (f == TMPS_FN_OUT_LO);
   endfunction

   // Pin A of port n at nibble 2n, pin B at 2n+1
   wire         acc_w    = psel_i & penable_i;
   wire         wr_w     = acc_w & pwrite_i;
   wire         hit_lo   = paddr_i == `TMPS_OFF_CFG_LO;
   wire         hit_hi   = paddr_i == `TMPS_OFF_CFG_HI;
   wire         hit_ctrl = paddr_i == `TMPS_OFF_CTRL;
   wire         hit_stat = paddr_i == `TMPS_OFF_STAT;
   wire         hit_any  = hit_lo | hit_hi | hit_ctrl | hit_stat;
   wire         sw_tri   = ctrl_q[`TMPS_CTRL_TRI_BIT];
   wire         drx_en   = ctrl_q[`TMPS_CTRL_DRX_BIT];
   wire         fall_sel = ctrl_q[`TMPS_CTRL_EDGE_BIT];
   wire  [7:0]  edge_w;
   logic [31:0] rd_mux;

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         cfg_lo_q <= `TMPS_CFG_RST;
         cfg_hi_q <= `TMPS_CFG_RST;
         ctrl_q   <= `TMPS_CTRL_RST;
      end else begin
         if (wr_w && hit_lo) cfg_lo_q <= pwdata_i;
         if (wr_w && hit_hi) cfg_hi_q <= pwdata_i;
         if (wr_w && hit_ctrl) ctrl_q <= pwdata_i[2:0];
      end
   end

   // Pins are foreign: two flops before any logic
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q   <= '1;
         pin_s2_q   <= '1;
         fclk_s1_q  <= 8'h00;
         fclk_s2_q  <= 8'h00;
         fclk_s3_q  <= 8'h00;
         negin_s1_q <= 8'h00;
         negin_s2_q <= 8'h00;
      end else begin
         pin_s1_q   <= pin_i;
         pin_s2_q   <= pin_s1_q;
         fclk_s1_q  <= fclk_i;
         fclk_s2_q  <= fclk_s1_q;
         fclk_s3_q  <= fclk_s2_q;
         negin_s1_q <= neg_data_i;
         negin_s2_q <= negin_s1_q;
      end
   end

   // Framer clock is slow beside clk_i, so its edges are found by sampling
   assign edge_w = fall_sel ? (fclk_s3_q & ~fclk_s2_q)
                            : (~fclk_s3_q & fclk_s2_q);

   genvar gp;
   generate
      for (gp = 0; gp < `TMPS_NPORT; gp++) begin : g_port
         wire [3:0] fa = fn_of(cfg_lo_q, cfg_hi_q, 2*gp);
         wire [3:0] fb = fn_of(cfg_lo_q, cfg_hi_q, 2*gp+1);
         assign pin_oe_o.a[gp] = fn_is_out(fa);
         assign pin_oe_o.b[gp] = fn_is_out(fb);
         assign pin_o.a[gp]    = (fa == TMPS_FN_OUT_HI);
         assign pin_o.b[gp]    = (fb == TMPS_FN_OUT_HI);
         // (either or both pins of a port may carry it; their results are ORed)
         wire tri_a = ((fa == TMPS_FN_TRI_HI) &  pin_s2_q.a[gp]) |
                      ((fa == TMPS_FN_TRI_LO) & ~pin_s2_q.a[gp]);
         wire tri_b = ((fb == TMPS_FN_TRI_HI) &  pin_s2_q.b[gp]) |
                      ((fb == TMPS_FN_TRI_LO) & ~pin_s2_q.b[gp]);
         // negative rail from whichever pin carries it, else data pin
         wire neg_src = (fa == TMPS_FN_NEG_IN) ? pin_s2_q.a[gp] :
                        (fb == TMPS_FN_NEG_IN) ? pin_s2_q.b[gp] :
                        negin_s2_q[gp];
         always_ff @(posedge clk_i or negedge rst_b) begin
            if (!rst_b) begin
               gpi_q.a[gp]    <= 1'b1;
               gpi_q.b[gp]    <= 1'b1;
               tri_line_q[gp] <= 1'b0;
               neg_q[gp]      <= 1'b0;
            end else begin
               if (fa == TMPS_FN_GPI) gpi_q.a[gp] <= pin_s2_q.a[gp];
               if (fb == TMPS_FN_GPI) gpi_q.b[gp] <= pin_s2_q.b[gp];
               tri_line_q[gp] <= sw_tri | tri_a | tri_b;
               if (!drx_en) begin
                  neg_q[gp] <= 1'b0;
               end else if (edge_w[gp]) begin
                  neg_q[gp] <= neg_src;
               end
            end
         end
      end
   endgenerate

   assign neg_data_o      = neg_q;
   assign line_tristate_o = tri_line_q;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_lo)   rd_mux = cfg_lo_q;
      if (hit_hi)   rd_mux = cfg_hi_q;
      if (hit_ctrl) rd_mux = {29'h0, ctrl_q};
      if (hit_stat) rd_mux = {16'h0, gpi_q};
   end

   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_q <= rd_mux;
      end
   end

   // Zero wait states; unmapped addresses answer with an error
   assign prdata_o  = prdata_q;
   assign pready_o  = 1'b1;
   assign pslverr_o = acc_w & ~hit_any;

   property p_reset_inputs;
      @(posedge clk_i) $rose(rst_b) |-> (pin_oe_o == '0);
   endproperty
   a_reset_inputs: assert property (p_reset_inputs)
      else $error("pin drives right after reset");

   property p_oe_follows;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[3:0] == 4'ha) |-> pin_oe_o.a[0] && pin_o.a[0];
   endproperty
   a_oe_follows: assert property (p_oe_follows)
      else $error("high output code not driving high");

   property p_low_out;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[7:4] == 4'hb) |-> pin_oe_o.b[0] && !pin_o.b[0];
   endproperty
   a_low_out: assert property (p_low_out)
      else $error("low output code wrong");

   property p_input_no_drive;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[3:0] inside {4'h8, 4'h9, 4'hd, 4'he}) |-> !pin_oe_o.a[0];
   endproperty
   a_input_no_drive: assert property (p_input_no_drive)
      else $error("input function drives pin");

   property p_sw_tri;
      @(posedge clk_i) disable iff (!rst_b)
      sw_tri |=> line_tristate_o == 8'hff;
   endproperty
   a_sw_tri: assert property (p_sw_tri)
      else $error("software tristate ignored");

   property p_tri_hi;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[3:0] == 4'h8 && pin_s2_q.a[0]) |=> line_tristate_o[0];
   endproperty
   a_tri_hi: assert property (p_tri_hi)
      else $error("high tristate pin ignored");

   property p_tri_lo;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[3:0] == 4'he && !pin_s2_q.a[0]) |=> line_tristate_o[0];
   endproperty
   a_tri_lo: assert property (p_tri_lo)
      else $error("low tristate pin ignored");

   property p_gpi_sync;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[3:0] == 4'h9) ##1 (cfg_lo_q[3:0] == 4'h9)
         |-> gpi_q.a[0] == $past(pin_i.a[0], 3);
   endproperty
   a_gpi_sync: assert property (p_gpi_sync)
      else $error("status does not follow pin after sync");

   property p_neg_hold;
      @(posedge clk_i) disable iff (!rst_b)
      (drx_en && !edge_w[0]) |=> $stable(neg_data_o[0]);
   endproperty
   a_neg_hold: assert property (p_neg_hold)
      else $error("negative data moved off the selected edge");

   property p_cfg_write;
      @(posedge clk_i) disable iff (!rst_b)
      (wr_w && hit_lo) |=> cfg_lo_q == $past(pwdata_i);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("config write not stored");

   property p_port7_map;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_hi_q[31:28] == 4'ha) |-> pin_oe_o.b[7] && pin_o.b[7];
   endproperty
   a_port7_map: assert property (p_port7_map)
      else $error("top nibble does not steer pin b of port 7");

   property p_gpi_b_sync;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[7:4] == 4'h9) ##1 (cfg_lo_q[7:4] == 4'h9)
         |-> gpi_q.b[0] == $past(pin_i.b[0], 3);
   endproperty
   a_gpi_b_sync: assert property (p_gpi_b_sync)
      else $error("pin b status does not follow pin after sync");

   property p_gpi_hold;
      @(posedge clk_i) disable iff (!rst_b)
      (cfg_lo_q[3:0] != 4'h9) |=> $stable(gpi_q.a[0]);
   endproperty
   a_gpi_hold: assert property (p_gpi_hold)
      else $error("status bit moved while pin is not a general input");

   property p_reset_quiet;
      @(posedge clk_i) $rose(rst_b) |->
         (line_tristate_o == 8'h00) && (neg_data_o == 8'h00);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("line outputs active right after reset");

   property p_neg_off;
      @(posedge clk_i) disable iff (!rst_b)
      !drx_en |=> neg_data_o == 8'h00;
   endproperty
   a_neg_off: assert property (p_neg_off)
      else $error("negative data present in single rail mode");

   // Latched value is the synchronised pin level seen on the edge cycle
   property p_neg_latch;
      @(posedge clk_i) disable iff (!rst_b)
      (drx_en && edge_w[0] && cfg_lo_q[3:0] == 4'hd)
         |=> neg_data_o[0] == $past(pin_s2_q.a[0]);
   endproperty
   a_neg_latch: assert property (p_neg_latch)
      else $error("negative data not taken from pin on selected edge");

   c_tri_lo: cover property (@(posedge clk_i) line_tristate_o[0] && !sw_tri);
   c_neg: cover property (@(posedge clk_i) drx_en && edge_w[0]);
   c_gpi: cover property (@(posedge clk_i) cfg_lo_q[3:0] == 4'h9);
   c_port7_out: cover property (@(posedge clk_i) pin_oe_o.b[7]);
endmodule

// *** bench/tmps_framer.sv ***
// Framer-side model of the transmit pins, clocks and rail data
`timescale 1ns/10ps
module tmps_framer
   import tmps_pkg::*;
(
   input  wire logic       clk_i,
   output logic [7:0]      fclk_o,
   output logic [7:0]      neg_o,
   output tmps_pins_s      drv_o,
   output tmps_pins_s      en_o
);
   initial begin
      fclk_o = 8'h00;
      neg_o = 8'h00;
      drv_o = 16'h0000;
      en_o = 16'h0000;
   end
   task automatic pins(input tmps_pins_s v, input tmps_pins_s m);
      @(posedge clk_i);
      drv_o <= v;
      en_o <= m;
   endtask
   // Each value is launched away from the edge meant to latch it
   task automatic burst(input logic [7:0] v1, input logic [7:0] v2);
      @(posedge clk_i);
      drv_o.a <= v1;
      neg_o <= ~v1;
      repeat (8) @(posedge clk_i);
      fclk_o <= 8'hff;
      repeat (6) @(posedge clk_i);
      drv_o.a <= v2;
      neg_o <= ~v2;
      repeat (2) @(posedge clk_i);
      fclk_o <= 8'h00;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

// *** bench/tmps_tb_top.sv ***
// Self-checking bench for the transmit pin selector
`timescale 1ns/10ps
`include "tmps_defs.svh"
module tmps_tb_top;
   import tmps_pkg::*;
   logic        clk_i = 1'h0;
   logic        rst_b_i = 1'h0;
   logic        psel = 1'h0;
   logic        pen = 1'h0;
   logic        pwr = 1'h0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, rv;
   logic        rdy, serr, ev;
   tmps_pins_s  po, oe, pw, fd, fe;
   logic [7:0]  fclk, fneg, nego, tri_o;
   int          miscompares = 0;
   int          checks = 0;
   int          cyc = 0;
   always #10 clk_i = ~clk_i;
   // Released pins float up to the pull-up level
   assign pw = (oe & po) | (~oe & (fe & fd | ~fe));
   tmps_top u_tmps_top (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
      .pready_o(rdy), .pslverr_o(serr), .pin_i(pw), .pin_o(po),
      .pin_oe_o(oe), .fclk_i(fclk), .neg_data_i(fneg),
      .neg_data_o(nego), .line_tristate_o(tri_o));
   tmps_framer u_tmps_framer (.clk_i(clk_i), .fclk_o(fclk),
      .neg_o(fneg), .drv_o(fd), .en_o(fe));
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         $display("CHECK FAILED %0t timeout", $time);
         close_out();
      end
   end
   task automatic chk(input logic [31:0] g, x, input string m);
      checks++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'h1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk_i);
      pen <= 1'h1;
      do @(posedge clk_i); while (rdy !== 1'h1);
      rv = prd;
      ev = serr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(rv, x, "read");
   endtask
   task automatic cfg(input logic [31:0] d);
      apb(1'h1, `TMPS_OFF_CFG_LO, d);
      apb(1'h1, `TMPS_OFF_CFG_HI, d);
      wt(1);
   endtask
   task automatic t_reset();
      chk({16'h0, oe}, 32'h0, "oe after reset");
      rd(`TMPS_OFF_CFG_LO, `TMPS_CFG_RST);
      rd(`TMPS_OFF_CTRL, 32'(`TMPS_CTRL_RST));
      rd(`TMPS_OFF_STAT, 32'h0000_ffff);
      apb(1'h1, `TMPS_OFF_STAT, 32'h0);
      rd(`TMPS_OFF_STAT, 32'h0000_ffff);
      rd(12'h010, 32'h0);
      chk({31'h0, ev}, 32'h1, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_codes();
      logic [3:0] t [7] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
      foreach (t[i]) begin
         cfg({8{t[i]}});
         chk({16'h0, oe}, t[i][3:1] == 3'h5 ? 32'hffff : 32'h0, "oe");
         chk({16'h0, po}, t[i] == 4'ha ? 32'hffff : 32'h0, "lvl");
      end
      apb(1'h1, `TMPS_OFF_CFG_LO, 32'h0000_00ab);
      apb(1'h1, `TMPS_OFF_CFG_HI, 32'hb000_0000);
      wt(1);
      chk({16'h0, oe}, 32'h0181, "oe map");
      chk({16'h0, po}, 32'h0001, "level map");
      $display("test codes done");
   endtask
   task automatic t_gpi();
      cfg(32'h9999_9999);
      u_tmps_framer.pins(16'h5a3c, 16'hffff);
      wt(5);
      rd(`TMPS_OFF_STAT, 32'h0000_5a3c);
      u_tmps_framer.pins(16'h0, 16'h0);
      wt(5);
      rd(`TMPS_OFF_STAT, 32'h0000_ffff);
      $display("test gpi done");
   endtask
   task automatic t_tri();
      cfg(32'he8e8_e8e8);
      u_tmps_framer.pins(16'h03f0, 16'hffff);
      wt(5);
      chk({24'h0, tri_o}, 32'h0f, "pin tri");
      apb(1'h1, `TMPS_OFF_CTRL, 32'h1 << `TMPS_CTRL_TRI_BIT);
      wt(3);
      chk({24'h0, tri_o}, 32'hff, "sw tri");
      apb(1'h1, `TMPS_OFF_CTRL, 32'h0);
      $display("test tristate done");
   endtask
   task automatic t_neg();
      cfg(32'h0d0d_0d0d);
      u_tmps_framer.pins(16'h0, 16'hff00);
      for (int e = 0; e < 2; e++) begin
         apb(1'h1, `TMPS_OFF_CTRL, (32'h1 << `TMPS_CTRL_DRX_BIT) |
             (32'(e) << `TMPS_CTRL_EDGE_BIT));
         u_tmps_framer.burst(8'ha5, 8'h5a);
         chk({24'h0, nego}, e ? 32'h5a : 32'ha5, "edge");
      end
      cfg(32'h0);
      u_tmps_framer.burst(8'ha5, 8'h5a);
      chk({24'h0, nego}, 32'ha5, "data pin");
      apb(1'h1, `TMPS_OFF_CTRL, 32'h0);
      wt(4);
      chk({24'h0, nego}, 32'h0, "single rail");
      $display("test negative rail done");
   endtask
   initial begin
      wt(3);
      rst_b_i <= 1'h1;
      wt(4);
      t_reset();
      t_codes();
      t_gpi();
      t_tri();
      t_neg();
      close_out();
   end
endmodule
